// file: src/nvm_pkg.sv
// Overview of operation
// - The slave answers only when the three select bits of the address byte equal its select pins.
// - A select pin left open reads as zero because the pad pulls it down.
// - The data line is only ever pulled low or released, never driven high.
// - Incoming bits are sampled on the rising clock edge, outgoing bits change after the falling edge.
// - Write-protect high blocks every write to the array, low lets every write through.
// - A write-protect pin left open reads low, so writes are enabled by default.
// - The array holds 32768 bytes, each shifted serially in or out over the data line.
// - Each access carries a slave address and a write carries a two-byte memory address after it.
// - The top bit of the two-byte memory address is ignored and the other 15 bits pick the byte.
// - A received data byte is committed to the array as soon as its eighth bit arrives.
// - A new transaction is accepted straight after a write, with no busy state or polling.
// - Serial clock rates up to 1 MHz are handled, and 100 kHz and 400 kHz as well.
// - The address byte holds a 4-bit type code on top, three select bits, and read-not-write in bit 0.
// - The address latch increments after every data byte, wraps from 7FFF to 0000, and reads start there.
// - A read keeps sending bytes while the master acknowledges and ends on a missing acknowledge.
// - A STOP seen during an operation aborts it and leaves the slave ready for the next one.
package nvm_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int          MEM_DEPTH = 32768;
  localparam int          ADDR_W    = 15;
  localparam int          DATA_W    = 8;
  localparam int          SEL_W     = 3;
  localparam logic [14:0] ADDR_LAST = 15'h7FFF;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;

  // ----------------------------------------------------------------
  // Address byte fields and bit counting
  // ----------------------------------------------------------------
  localparam int         TYPE_MSB  = 7;
  localparam int         TYPE_LSB  = 4;
  localparam int         SEL_MSB   = 3;
  localparam int         SEL_LSB   = 1;
  localparam int         RNW_POS   = 0;
  localparam logic [3:0] TYPE_CODE = 4'h6;  // Arbitrary value
  localparam logic [3:0] BIT_LAST  = 4'h7;
  localparam logic [3:0] BIT_ACK   = 4'h8;
  localparam logic [3:0] BIT_ZERO  = 4'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CORE_PERIOD_NS    = 40;
  localparam int SCL_MIN_PERIOD_NS = 1000;
  localparam int SCL_MIN_CYC       = (SCL_MIN_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int SYNC_SLACK_CYC    = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'b00_0001,
    ST_DEVADDR = 6'b00_0010,
    ST_ADDRHI  = 6'b00_0100,
    ST_ADDRLO  = 6'b00_1000,
    ST_WDATA   = 6'b01_0000,
    ST_RDATA   = 6'b10_0000
  } nvm_state_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } nvm_wreq_t;

endpackage

// file: src/nvm_sync.sv
`timescale 1ns/10ps
module nvm_sync #(
  parameter int         W   = 1,
  parameter logic [7:0] RST = 8'h00
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= RST[W-1:0];
      q      <= RST[W-1:0];
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: src/nvm_array.sv
`timescale 1ns/10ps
module nvm_array
  import nvm_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW    = ADDR_W
) (
  input  wire logic              core_clk,
  input  wire nvm_pkg::nvm_wreq_t wr,
  input  wire logic [AW-1:0]     rdAddr,
  output logic      [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [DEPTH];

  // Byte-wide storage, write and registered read
  always_ff @(posedge core_clk) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
    rdData <= mem[rdAddr];
  end
endmodule

// file: src/nvm_i2c_slave.sv
`timescale 1ns/10ps
module nvm_i2c_slave (
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  input  wire logic                      sclClk,
  input  wire logic                      sdaIn,
  output logic                           sdaOut,
  output logic                           sdaOe,
  input  wire logic                      wpPin,
  input  wire logic [nvm_pkg::SEL_W-1:0] devSelectPins
);
  import nvm_pkg::*;

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  logic riseTgl_q = 1'b0;
  logic rxBit_q   = 1'b1;

  // Sample data on each rising serial clock and flag the edge
  always_ff @(posedge sclClk) begin
    riseTgl_q <= ~riseTgl_q;
    rxBit_q   <= sdaIn;
  end

  // ----------------------------------------------------------------
  // Crossings into the core domain
  // ----------------------------------------------------------------
  logic             sclS;
  logic             sdaS;
  logic             wpS;
  logic [SEL_W-1:0] selS;
  logic             riseS;

  // Pin levels; pads pull open select and protect pins low
  // Reset value matches the idle bus: clock high, data high, unprotected
  nvm_sync #(.W(SEL_W + 3), .RST(8'h30)) uPinSync (
    .core_clk (core_clk),
    .srst     (srst),
    .d        ({sclClk, sdaIn, wpPin, devSelectPins}),
    .q        ({sclS, sdaS, wpS, selS})
  );

  // Rising-edge toggle, latency well inside the shortest clock phase
  // Runs through reset so the edge detector never sees a false step
  nvm_sync #(.W(1), .RST(8'h00)) uRiseSync (
    .core_clk (core_clk),
    .srst     (1'b0),
    .d        (riseTgl_q),
    .q        (riseS)
  );

  // ----------------------------------------------------------------
  // Bus condition detection
  // ----------------------------------------------------------------
  logic sclPrev_q;
  logic sdaPrev_q;
  logic riseSeen_q;
  logic riseEv;
  logic fallEv;
  logic startEv;
  logic stopEv;

  // Previous levels for edge detection
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sclPrev_q  <= 1'b1;
      sdaPrev_q  <= 1'b1;
      riseSeen_q <= riseS;
    end else begin
      sclPrev_q  <= sclS;
      sdaPrev_q  <= sdaS;
      riseSeen_q <= riseS;
    end
  end

  // Data edge while clock high marks START or STOP
  assign riseEv  = riseS ^ riseSeen_q;
  assign fallEv  = sclPrev_q & ~sclS;
  assign startEv = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
  assign stopEv  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

  // ----------------------------------------------------------------
  // Protocol state
  // ----------------------------------------------------------------
  nvm_state_t         state_q;
  logic [3:0]         bitCnt_q;
  logic [7:0]         shift_q;
  logic [7:0]         rdSh_q;
  logic [6:0]         addrHi_q;
  logic [ADDR_W-1:0]  addr_q;
  logic               rnw_q;
  logic               drvLow_q;
  logic               sdaOe_q;
  logic               sdaOut_q;
  nvm_wreq_t          wr_q;
  logic [DATA_W-1:0]  rdData;
  logic [7:0]         byteVal;
  logic               devMatch;
  logic               byteDone;
  logic               ackSlot;

  assign byteVal  = {shift_q[6:0], rxBit_q};
  assign devMatch = (byteVal[TYPE_MSB:TYPE_LSB] == TYPE_CODE)
                  & (byteVal[SEL_MSB:SEL_LSB] == selS);
  assign byteDone = riseEv & (bitCnt_q == BIT_LAST);
  assign ackSlot  = riseEv & (bitCnt_q == BIT_ACK);

  // State sequencing per byte and acknowledge slot
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      rnw_q   <= 1'b0;
    end else if (stopEv) begin
      state_q <= ST_IDLE;
    end else if (startEv) begin
      state_q <= ST_DEVADDR;
    end else if (byteDone && state_q == ST_DEVADDR) begin
      if (devMatch) begin
        rnw_q <= byteVal[RNW_POS];
      end else begin
        state_q <= ST_IDLE;
      end
    end else if (ackSlot) begin
      case (state_q)
        ST_DEVADDR: begin
          state_q <= rnw_q ? ST_RDATA : ST_ADDRHI;
        end
        ST_ADDRHI: begin
          state_q <= ST_ADDRLO;
        end
        ST_ADDRLO: begin
          state_q <= ST_WDATA;
        end
        ST_RDATA: begin
          if (rxBit_q) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // Bit counter and receive shifter
  always_ff @(posedge core_clk) begin
    if (srst || startEv || stopEv) begin
      bitCnt_q <= BIT_ZERO;
      shift_q  <= 8'h00;
    end else if (riseEv) begin
      if (bitCnt_q == BIT_ACK) begin
        bitCnt_q <= BIT_ZERO;
      end else begin
        bitCnt_q <= bitCnt_q + 4'h1;
        shift_q  <= byteVal;
      end
    end
  end

  // Memory address: two bytes loaded, then step after each byte
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addrHi_q <= 7'h00;
      addr_q   <= ADDR_ZERO;
    end else if (byteDone && !stopEv && !startEv) begin
      if (state_q == ST_ADDRHI) begin
        addrHi_q <= byteVal[6:0];
      end else if (state_q == ST_ADDRLO) begin
        addr_q <= {addrHi_q, byteVal};
      end else if (state_q == ST_WDATA || state_q == ST_RDATA) begin
        addr_q <= (addr_q == ADDR_LAST) ? ADDR_ZERO : addr_q + 15'h0001;
      end
    end
  end

  // Array write issued on the eighth bit unless protected
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wr_q <= '0;
    end else begin
      wr_q.en   <= byteDone & (state_q == ST_WDATA) & ~wpS & ~stopEv & ~startEv;
      wr_q.addr <= addr_q;
      wr_q.data <= byteVal;
    end
  end

  nvm_array #(.DEPTH(MEM_DEPTH), .AW(ADDR_W)) uArray (
    .core_clk (core_clk),
    .wr       (wr_q),
    .rdAddr   (addr_q),
    .rdData   (rdData)
  );

  // Requested line level for the next falling clock
  always_ff @(posedge core_clk) begin
    if (srst || startEv || stopEv) begin
      drvLow_q <= 1'b0;
      rdSh_q   <= 8'h00;
    end else if (riseEv) begin
      if (bitCnt_q == BIT_ACK) begin
        if ((state_q == ST_DEVADDR && rnw_q) || (state_q == ST_RDATA && !rxBit_q)) begin
          rdSh_q   <= rdData;
          drvLow_q <= ~rdData[7];
        end else begin
          drvLow_q <= 1'b0;
        end
      end else if (state_q == ST_RDATA) begin
        drvLow_q <= (bitCnt_q == BIT_LAST) ? 1'b0 : ~rdSh_q[6];
        rdSh_q   <= {rdSh_q[6:0], 1'b0};
      end else if (bitCnt_q == BIT_LAST) begin
        drvLow_q <= (state_q == ST_DEVADDR) ? devMatch : (state_q != ST_IDLE);
      end else begin
        drvLow_q <= 1'b0;
      end
    end
  end

  // Open-drain pin stage, changes after a falling clock, released at once by START or STOP
  always_ff @(posedge core_clk) begin
    if (srst || startEv || stopEv) begin
      sdaOe_q <= 1'b0;
    end else if (fallEv) begin
      sdaOe_q <= drvLow_q;
    end
  end

  // Output level is always low, the pull-up makes the high
  always_ff @(posedge core_clk) begin
    sdaOut_q <= 1'b0;
  end

  assign sdaOut = sdaOut_q;
  assign sdaOe  = sdaOe_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic [7:0] gap_q;

  // Cycles since the last rising clock, saturating
  always_ff @(posedge core_clk) begin
    if (srst || riseEv) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hFF) begin
      gap_q <= gap_q + 8'h01;
    end
  end

  sequence wrByteS;
    byteDone && state_q == ST_WDATA && !stopEv && !startEv;
  endsequence

  sequence rdNackS;
    ackSlot && state_q == ST_RDATA && rxBit_q && !stopEv && !startEv;
  endsequence

  addr_match_a: assert property (
    byteDone && state_q == ST_DEVADDR && !devMatch && !stopEv && !startEv |=> state_q == ST_IDLE)
    else $error("Unmatched address byte did not drop the slave");
  open_drain_a: assert property (sdaOut == 1'b0)
    else $error("Data line driven high");
  drive_edge_a: assert property (
    $rose(sdaOe) |-> $past(fallEv))
    else $error("Data line pulled low outside a falling clock");
  write_prot_a: assert property (
    wrByteS ##1 wr_q.en |-> !$past(wpS))
    else $error("Write reached array while protected");
  write_commit_a: assert property (
    wrByteS and !wpS |=> wr_q.en && wr_q.data == $past(byteVal) && wr_q.addr == $past(addr_q))
    else $error("Received byte not committed");
  prot_ack_a: assert property (wrByteS |=> drvLow_q)
    else $error("Write byte not acknowledged");
  addr_wrap_a: assert property (
    (wrByteS or (byteDone && state_q == ST_RDATA && !stopEv && !startEv))
    ##0 addr_q == ADDR_LAST |=> addr_q == ADDR_ZERO)
    else $error("Address latch did not wrap");
  addr_msb_a: assert property (
    byteDone && state_q == ST_ADDRLO && !stopEv && !startEv
    |=> addr_q[14:8] == $past(addrHi_q) && addr_q[7:0] == $past(byteVal))
    else $error("Memory address not loaded from low 15 bits");
  read_end_a: assert property (rdNackS |=> state_q == ST_IDLE && !drvLow_q)
    else $error("Read continued after missing acknowledge");
  stop_abort_a: assert property (
    stopEv |=> state_q == ST_IDLE && !sdaOe_q && bitCnt_q == BIT_ZERO)
    else $error("STOP did not abort operation");
  start_ready_a: assert property (
    startEv && !stopEv |=> state_q == ST_DEVADDR [*1] ##0 bitCnt_q == BIT_ZERO)
    else $error("START not accepted at once");
  rate_gap_a: assert property (
    riseEv |-> gap_q >= 8'(SCL_MIN_CYC - SYNC_SLACK_CYC - 1))
    else $error("Serial clock faster than supported");

endmodule

// file: sim/nvm_i2c_master_bfm.sv
`timescale 1ns/10ps
// Bus master model: owns the serial clock, only pulls the data line low or lets it go
module nvm_i2c_master_bfm #(
  parameter int HALF = 84
) (
  input  wire logic linkTick,
  input  wire logic sdaWire,
  output logic      sclClk,
  output logic      sdaPull
);
  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Clock stands high and data is released between frames
  initial begin
    sclClk  = 1'b1;
    sdaPull = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge linkTick);
  endtask
  // Half period of 84 ticks of 6 ns keeps the clock under 1 MHz
  task automatic start();
    gap(HALF / 2);
    sdaPull <= 1'b0;
    gap(HALF / 2);
    sclClk <= 1'b1;
    gap(HALF);
    sdaPull <= 1'b1;
    gap(HALF);
    sclClk <= 1'b0;
  endtask
  // Data rises while the clock is high
  task automatic stop();
    gap(HALF / 2);
    sdaPull <= 1'b1;
    gap(HALF / 2);
    sclClk <= 1'b1;
    gap(HALF);
    sdaPull <= 1'b0;
    gap(HALF);
  endtask
  // One clock: data set while low, sampled after the rise and again before the fall
  task automatic put_bit(input logic b, output logic seen, output logic held);
    gap(HALF / 2);
    sdaPull <= ~b;
    gap(HALF / 2);
    sclClk <= 1'b1;
    gap(2);
    seen = sdaWire;
    gap(HALF - 2);
    held = (sdaWire === seen);
    sclClk <= 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge slot
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    logic h;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], s, h);
    end
    put_bit(1'b1, s, h);
    ack = ~s;
  endtask
  // Acknowledges to continue, withholds it on the last byte
  task automatic read_byte(input logic more, output logic [7:0] d, output logic steady);
    logic s;
    logic h;
    steady = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s, h);
      d[i]   = s;
      steady = steady & h;
    end
    put_bit(~more, s, h);
  endtask
endmodule

// file: sim/nvm_i2c_slave_tb.sv
`timescale 1ns/10ps
module nvm_i2c_slave_tb;
  import nvm_pkg::*;
  logic       core_clk = 1'b0;
  logic       linkTick = 1'b0;
  logic       srst     = 1'b1;
  logic       wpPin    = 1'b0;
  logic [2:0] devSel   = 3'h0;
  logic       sclClk;
  logic       sdaPull;
  logic       sdaOut;
  logic       sdaOe;
  logic       sdaWire;
  logic       st;
  logic [7:0] wdat [8];
  logic [7:0] rdat [8];
  int         fails          = 0;
  int         samplesChecked = 0;
  // ----------------------------------------
  // Clocks, wire and instances
  // ----------------------------------------
  always #20 core_clk = ~core_clk;
  always #3 linkTick = ~linkTick;
  assign sdaWire = ~(sdaPull | sdaOe);
  nvm_i2c_slave i_nvm_i2c_slave (
    .core_clk      (core_clk),
    .srst          (srst),
    .sclClk        (sclClk),
    .sdaIn         (sdaWire),
    .sdaOut        (sdaOut),
    .sdaOe         (sdaOe),
    .wpPin         (wpPin),
    .devSelectPins (devSel)
  );
  nvm_i2c_master_bfm i_nvm_i2c_master_bfm (
    .linkTick (linkTick),
    .sdaWire  (sdaWire),
    .sclClk   (sclClk),
    .sdaPull  (sdaPull)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  function automatic logic [7:0] dev(input logic [3:0] t, input logic [2:0] s, input logic r);
    return {t, s, r};
  endfunction
  task automatic bs();
    i_nvm_i2c_master_bfm.start();
  endtask
  task automatic bp();
    i_nvm_i2c_master_bfm.stop();
  endtask
  // Sends one byte and compares the acknowledge with the expectation
  task automatic bw(input logic [7:0] b, input logic e, input string w);
    logic a;
    i_nvm_i2c_master_bfm.write_byte(b, a);
    check(w, {7'h00, a}, {7'h00, e});
  endtask
  task automatic setp(input logic w, input logic [2:0] s);
    @(posedge core_clk);
    wpPin  <= w;
    devSel <= s;
    repeat (4) @(posedge core_clk);
  endtask
  // Start, write header and two address bytes
  task automatic hdr(input logic [15:0] a);
    bs();
    bw(dev(TYPE_CODE, devSel, 1'b0), 1'b1, "dev ack");
    bw(a[15:8], 1'b1, "addr hi ack");
    bw(a[7:0], 1'b1, "addr lo ack");
  endtask
  task automatic wr(input logic [15:0] a, input int n);
    hdr(a);
    for (int k = 0; k < n; k++) begin
      bw(wdat[k], 1'b1, "data ack");
    end
    bp();
  endtask
  // Random read: address loaded by a write header, then repeated start
  task automatic rd(input logic [15:0] a, input int n);
    hdr(a);
    bs();
    bw(dev(TYPE_CODE, devSel, 1'b1), 1'b1, "rd dev ack");
    for (int k = 0; k < n; k++) begin
      i_nvm_i2c_master_bfm.read_byte(k < n - 1, rdat[k], st);
      check("read steady", {7'h00, st}, 8'h01);
    end
    bp();
  endtask
  // Slave may only pull low while it drives, looked at once settled
  always @(negedge core_clk) begin
    if (!srst && sdaOe === 1'b1) begin
      check("sdaOut level", {7'h00, sdaOut}, 8'h00);
    end
  end
  // Cuts a hung run short
  initial begin
    #3_000_000;
    fails++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] a;
    logic [7:0]  keep;
    void'($urandom(93));
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    repeat (4) @(posedge core_clk);
    check("idle oe", {7'h00, sdaOe}, 8'h00);
    // Burst with the ignored top address bit set, read back without it
    a = {1'b1, 15'($urandom())};
    for (int k = 0; k < 6; k++) begin
      wdat[k] = 8'($urandom());
    end
    wr(a, 6);
    rd({1'b0, a[14:0]}, 6);
    for (int k = 0; k < 6; k++) begin
      check("burst data", rdat[k], wdat[k]);
    end
    $display("test burst done");
    // Wrap from the last location to the first
    wdat[0] = 8'($urandom());
    wdat[1] = 8'($urandom());
    wr(16'h7FFF, 2);
    rd(16'h7FFF, 2);
    for (int k = 0; k < 2; k++) begin
      check("wrap data", rdat[k], wdat[k]);
    end
    $display("test wrap done");
    // Protected write is acknowledged but leaves the byte alone
    keep    = wdat[1];
    wdat[0] = ~keep;
    setp(1'b1, devSel);
    wr(16'h0000, 1);
    setp(1'b0, devSel);
    rd(16'h0000, 1);
    check("protected", rdat[0], keep);
    $display("test protect done");
    // Stop in mid byte discards it
    wdat[0] = 8'($urandom());
    wr(16'h0100, 1);
    hdr(16'h0100);
    for (int k = 0; k < 4; k++) begin
      i_nvm_i2c_master_bfm.put_bit(~wdat[0][7 - k], st, st);
    end
    bp();
    rd(16'h0100, 1);
    check("abort", rdat[0], wdat[0]);
    $display("test abort done");
    // Every select pin value against every select field and a wrong type code
    for (int p = 0; p < 8; p++) begin
      setp(1'b0, 3'(p));
      for (int s = 0; s < 8; s++) begin
        bs();
        bw(dev(TYPE_CODE, 3'(s), 1'b0), s == p, "select");
        bp();
      end
      bs();
      bw(dev(TYPE_CODE ^ 4'h8, 3'(p), 1'b0), 1'b0, "type");
      bp();
    end
    $display("test select done");
    print_verdict();
  end
endmodule
